// ---- core/ofd_consts.vh ----
// Summary of operation
// RULE_01: Register field selects V,A,B,C,D,E,H,L; narrow A-C.
// RULE_02: Alternate field selects accumulator halves then B-L.
// RULE_03: Move-destination special class reaches listed registers.
// RULE_04: Move-source special class adds receive buffer, results.
// RULE_05: Immediate special class limited to ports, masks, modes.
// RULE_06: Wide destination class selects compare registers only.
// RULE_07: Wide source class selects up-counter and capture.
// RULE_08: Pair classes resolve to their permitted pair sets.
// RULE_09: Basic indirect forms; restricted class plain only.
// RULE_10: Extended classes add indexed effective address forms.
// RULE_11: Wide transfer class: DE/HL, double-increment, indexed.
// RULE_12: Flag field selects carry, half-carry or zero.
// RULE_13: Interrupt-flag field selects one of listed sources.
// RULE_14: Immediates decoded by width: 8, 8, 16, 3 bits.
// RULE_15: Pair code order: SP, BC, DE, HL, accumulator.
// RULE_16: Unnamed or out-of-class codes flagged, never written; unnamed flag and interrupt-flag codes give zero without illegal_q.
`ifndef OFD_CONSTS_VH
`define OFD_CONSTS_VH
// Operand classes presented on sel_class.
`define OFD_CLS_R 4'h0
`define OFD_CLS_R1 4'h1
`define OFD_CLS_R2 4'h2
`define OFD_CLS_SR 4'h3
`define OFD_CLS_SR1 4'h4
`define OFD_CLS_SR2 4'h5
`define OFD_CLS_SR3 4'h6
`define OFD_CLS_SR4 4'h7
`define OFD_CLS_RP 4'h8
`define OFD_CLS_RP1 4'h9
`define OFD_CLS_RP2 4'ha
`define OFD_CLS_RP3 4'hb
`define OFD_CLS_RPA 4'hc
`define OFD_CLS_RPA1 4'hd
`define OFD_CLS_RPA2 4'he
`define OFD_CLS_RPA3 4'hf
// Special register codes.
`define OFD_SR_PORT_A 6'h00
`define OFD_SR_PORT_B 6'h01
`define OFD_SR_PORT_C 6'h02
`define OFD_SR_PORT_D 6'h03
`define OFD_SR_PORT_F 6'h04
`define OFD_SR_MASK_HI 6'h06
`define OFD_SR_MASK_LO 6'h07
`define OFD_SR_ADC_MODE 6'h08
`define OFD_SR_SER_HI 6'h09
`define OFD_SR_SER_LO 6'h0a
`define OFD_SR_CNT_OUT 6'h0b
`define OFD_SR_CNT_MODE 6'h0c
`define OFD_SR_TMR_MODE 6'h0d
`define OFD_SR_MEM_MAP 6'h10
`define OFD_SR_PC_CTRL 6'h11
`define OFD_SR_DIR_A 6'h12
`define OFD_SR_DIR_B 6'h13
`define OFD_SR_DIR_C 6'h14
`define OFD_SR_DIR_F 6'h17
`define OFD_SR_TX_BUF 6'h18
`define OFD_SR_RX_BUF 6'h19
`define OFD_SR_TMR0 6'h1a
`define OFD_SR_TMR1 6'h1b
`define OFD_SR_ADC_R0 6'h20
`define OFD_SR_ADC_R3 6'h23
`define OFD_SR_ZC 6'h28
// Register-pair resource codes (output rp_sel).
`define OFD_RP_SP 3'h0
`define OFD_RP_BC 3'h1
`define OFD_RP_DE 3'h2
`define OFD_RP_HL 3'h3
`define OFD_RP_EA 3'h4
`define OFD_RP_VA 3'h5
// Addressing codes (4-bit field).
`define OFD_AM_BC 4'h1
`define OFD_AM_DE 4'h2
`define OFD_AM_HL 4'h3
`define OFD_AM_DE_INC 4'h4
`define OFD_AM_HL_INC 4'h5
`define OFD_AM_DE_DEC 4'h6
`define OFD_AM_HL_DEC 4'h7
`define OFD_AM_DE_IDX 4'hb
`define OFD_AM_HL_A 4'hc
`define OFD_AM_HL_B 4'hd
`define OFD_AM_HL_EA 4'he
`define OFD_AM_HL_IDX 4'hf
// Narrow byte register class bounds.
`define OFD_REG_A 3'h1
`define OFD_REG_C 3'h3
// Flag and interrupt-flag limits.
`define OFD_FLG_CY 3'h2
`define OFD_FLG_HC 3'h3
`define OFD_FLG_Z 3'h4
`define OFD_IRF_LAST_LO 5'h0c
`define OFD_IRF_AN4 5'h10
`define OFD_IRF_AN5 5'h11
`define OFD_IRF_AN6 5'h12
`define OFD_IRF_AN7 5'h13
`define OFD_IRF_SB 5'h14
`define OFD_RESET_ZERO 16'h0000
`endif

// ---- core/ofd_sr_table.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ofd_consts.vh"
// Membership of a 6-bit special register code in the three byte classes.
module ofd_sr_table (
	// Code in
	input wire [5:0] code,
	// Class membership out
	output reg in_sr,
	output reg in_sr1,
	output reg in_sr2
);
	always @* begin
		in_sr = 1'b0;
		in_sr1 = 1'b0;
		in_sr2 = 1'b0;
		case (code)
			`OFD_SR_PORT_A, `OFD_SR_PORT_B, `OFD_SR_PORT_C, `OFD_SR_PORT_D,
			`OFD_SR_PORT_F, `OFD_SR_MASK_HI, `OFD_SR_MASK_LO, `OFD_SR_ADC_MODE,
			`OFD_SR_SER_HI, `OFD_SR_CNT_OUT, `OFD_SR_TMR_MODE: begin
				in_sr = 1'b1; // [RULE_03]
				in_sr1 = 1'b1; // [RULE_04]
				in_sr2 = 1'b1; // [RULE_05]
			end
			`OFD_SR_SER_LO, `OFD_SR_CNT_MODE, `OFD_SR_MEM_MAP, `OFD_SR_PC_CTRL,
			`OFD_SR_DIR_A, `OFD_SR_DIR_B, `OFD_SR_DIR_C, `OFD_SR_DIR_F,
			`OFD_SR_TX_BUF, `OFD_SR_TMR0, `OFD_SR_TMR1, `OFD_SR_ZC: begin
				in_sr = 1'b1; // [RULE_03]
			end
			`OFD_SR_RX_BUF: begin
				in_sr1 = 1'b1; // [RULE_04]
			end
			default: begin
				if (code >= `OFD_SR_ADC_R0 && code <= `OFD_SR_ADC_R3) begin
					in_sr1 = 1'b1; // [RULE_04]
				end
			end
		endcase
	end
endmodule
`default_nettype wire

// ---- core/ofd_decoder.v ----
`timescale 1ns/1ps
`default_nettype none
`include "ofd_consts.vh"
// Registered operand field decoder. One request per cycle; results one cycle later.
module ofd_decoder (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Request from decode stage
	input wire dec_valid,
	input wire [3:0] sel_class,
	input wire [5:0] sel_code,
	input wire [2:0] flag_code,
	input wire [4:0] irf_code,
	input wire [7:0] imm_lo,
	input wire [7:0] imm_hi,
	// Decoded results
	output reg res_valid_q,
	output reg [2:0] byte_reg_q,
	output reg byte_reg_alt_q,
	output reg [5:0] sr_sel_q,
	output reg sr_wide_q,
	output reg sr_write_q,
	output reg [2:0] rp_sel_q,
	output reg [3:0] addr_mode_q,
	output reg [2:0] flag_sel_q,
	output reg [4:0] irf_sel_q,
	output reg illegal_q,
	// Immediates by width
	output reg [7:0] working_reg_offset_q,
	output reg [7:0] imm_byte_q,
	output reg [15:0] imm_word_q,
	output reg [2:0] imm_bit_q
);
	wire in_sr;
	wire in_sr1;
	wire in_sr2;
	reg ok_d;
	reg wr_d;
	reg wide_d;
	reg alt_d;
	reg [2:0] rp_d;
	reg [3:0] am_d;
	reg flag_ok;
	reg irf_ok;
	reg am_basic;
	reg am_plain;
	reg am_wide;
	reg am_index;

	ofd_sr_table u_tab (
		.code(sel_code),
		.in_sr(in_sr),
		.in_sr1(in_sr1),
		.in_sr2(in_sr2)
	);

	always @* begin
		ok_d = 1'b0;
		wr_d = 1'b0;
		wide_d = 1'b0;
		alt_d = 1'b0;
		rp_d = `OFD_RP_SP;
		am_d = 4'h0;
		case (sel_class)
			`OFD_CLS_R: begin
				ok_d = 1'b1; // [RULE_01]
			end
			`OFD_CLS_R1: begin
				ok_d = 1'b1; // [RULE_02]
				alt_d = 1'b1;
			end
			`OFD_CLS_R2: begin
				ok_d = sel_code[2:0] >= `OFD_REG_A && sel_code[2:0] <= `OFD_REG_C; // [RULE_01]
			end
			`OFD_CLS_SR: begin
				ok_d = in_sr; // [RULE_03]
				wr_d = in_sr;
			end
			`OFD_CLS_SR1: begin
				ok_d = in_sr1; // [RULE_04]
			end
			`OFD_CLS_SR2: begin
				ok_d = in_sr2; // [RULE_05]
				wr_d = in_sr2;
			end
			`OFD_CLS_SR3: begin
				// One-bit code: compare register 0 or 1, loaded from the accumulator.
				ok_d = sel_code[5:1] == 5'h00; // [RULE_06]
				wr_d = ok_d;
				wide_d = 1'b1;
			end
			`OFD_CLS_SR4: begin
				ok_d = sel_code[5:1] == 5'h00; // [RULE_07]
				wide_d = 1'b1;
			end
			`OFD_CLS_RP, `OFD_CLS_RP2: begin
				rp_d = sel_code[2:0]; // [RULE_15]
				if (sel_class == `OFD_CLS_RP) begin
					ok_d = sel_code[2:0] <= `OFD_RP_HL; // [RULE_08]
				end else begin
					ok_d = sel_code[2:0] <= `OFD_RP_EA; // [RULE_08]
				end
			end
			`OFD_CLS_RP1: begin
				ok_d = sel_code[2:0] <= `OFD_RP_EA; // [RULE_08]
				rp_d = (sel_code[2:0] == 3'h0) ? `OFD_RP_VA : sel_code[2:0];
			end
			`OFD_CLS_RP3: begin
				ok_d = sel_code[2:0] >= `OFD_RP_BC && sel_code[2:0] <= `OFD_RP_HL; // [RULE_08]
				rp_d = sel_code[2:0];
			end
			`OFD_CLS_RPA: begin
				am_d = sel_code[3:0];
				ok_d = am_basic; // [RULE_09]
			end
			`OFD_CLS_RPA1: begin
				am_d = sel_code[3:0];
				ok_d = am_plain; // [RULE_09]
			end
			`OFD_CLS_RPA2: begin
				am_d = sel_code[3:0];
				ok_d = am_basic | am_index; // [RULE_10]
			end
			`OFD_CLS_RPA3: begin
				// No BC and no decrement: plain, double-step and indexed forms only.
				am_d = sel_code[3:0];
				ok_d = am_wide | am_index; // [RULE_11]
			end
			default: begin
				ok_d = 1'b0;
			end
		endcase
	end

	// Membership of a 4-bit addressing code in the indirect and indexed groups.
	always @* begin
		am_basic = 1'b0;
		am_plain = 1'b0;
		am_wide = 1'b0;
		am_index = 1'b0;
		case (sel_code[3:0])
			`OFD_AM_BC: begin
				am_basic = 1'b1; // [RULE_09]
				am_plain = 1'b1;
			end
			`OFD_AM_DE, `OFD_AM_HL: begin
				am_basic = 1'b1;
				am_plain = 1'b1;
				am_wide = 1'b1; // [RULE_11]
			end
			`OFD_AM_DE_INC, `OFD_AM_HL_INC: begin
				// Single step in the basic classes, double step in the wide class.
				am_basic = 1'b1;
				am_wide = 1'b1;
			end
			`OFD_AM_DE_DEC, `OFD_AM_HL_DEC: begin
				am_basic = 1'b1;
			end
			`OFD_AM_DE_IDX, `OFD_AM_HL_A, `OFD_AM_HL_B, `OFD_AM_HL_EA, `OFD_AM_HL_IDX: begin
				am_index = 1'b1; // [RULE_10]
			end
			default: begin
				am_index = 1'b0;
			end
		endcase
	end

	// Flag and interrupt-flag codes outside their tables give code zero.
	always @* begin
		case (flag_code)
			`OFD_FLG_CY, `OFD_FLG_HC, `OFD_FLG_Z: begin
				flag_ok = 1'b1; // [RULE_12]
			end
			default: begin
				flag_ok = 1'b0;
			end
		endcase
		case (irf_code)
			`OFD_IRF_AN4, `OFD_IRF_AN5, `OFD_IRF_AN6, `OFD_IRF_AN7, `OFD_IRF_SB: begin
				irf_ok = 1'b1; // [RULE_13]
			end
			default: begin
				irf_ok = irf_code <= `OFD_IRF_LAST_LO; // [RULE_13]
			end
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			res_valid_q <= 1'b0;
			byte_reg_q <= 3'h0;
			byte_reg_alt_q <= 1'b0;
			sr_sel_q <= 6'h00;
			sr_wide_q <= 1'b0;
			sr_write_q <= 1'b0;
			rp_sel_q <= `OFD_RP_SP;
			addr_mode_q <= 4'h0;
			flag_sel_q <= 3'h0;
			irf_sel_q <= 5'h00;
			illegal_q <= 1'b0;
			working_reg_offset_q <= 8'h00;
			imm_byte_q <= 8'h00;
			imm_word_q <= `OFD_RESET_ZERO;
			imm_bit_q <= 3'h0;
		end else begin
			res_valid_q <= dec_valid;
			byte_reg_q <= sel_code[2:0]; // [RULE_01] [RULE_02]
			byte_reg_alt_q <= alt_d;
			sr_sel_q <= wide_d ? {5'h00, sel_code[0]} : sel_code;
			sr_wide_q <= wide_d;
			// Illegal codes never produce a write strobe.
			sr_write_q <= dec_valid & ok_d & wr_d; // [RULE_16]
			illegal_q <= dec_valid & ~ok_d; // [RULE_16]
			rp_sel_q <= rp_d;
			addr_mode_q <= am_d;
			flag_sel_q <= flag_ok ? flag_code : 3'h0; // [RULE_12]
			irf_sel_q <= irf_ok ? irf_code : 5'h00; // [RULE_13]
			working_reg_offset_q <= imm_lo; // [RULE_14]
			imm_byte_q <= imm_lo; // [RULE_14]
			imm_word_q <= {imm_hi, imm_lo}; // [RULE_14]
			imm_bit_q <= imm_lo[2:0]; // [RULE_14]
		end
	end
endmodule
`default_nettype wire

// ---- test/ofd_decoder_props.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ofd_consts.vh"
module ofd_decoder_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Request
	input wire logic dec_valid,
	input wire logic [3:0] sel_class,
	input wire logic [5:0] sel_code,
	input wire logic [2:0] flag_code,
	input wire logic [7:0] imm_lo,
	input wire logic [7:0] imm_hi,
	// Results
	input wire logic res_valid_q,
	input wire logic sr_write_q,
	input wire logic illegal_q,
	input wire logic [2:0] flag_sel_q,
	input wire logic [15:0] imm_word_q,
	input wire logic [2:0] imm_bit_q
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_valid_follows: assert property (dec_valid |=> res_valid_q)
		else $error("request gave no result");
	a_idle_quiet: assert property (!dec_valid |=> !res_valid_q && !illegal_q && !sr_write_q)
		else $error("result without request");
	a_write_legal: assert property (sr_write_q |-> res_valid_q && !illegal_q)
		else $error("write on illegal operand");
	a_source_no_write: assert property (dec_valid && sel_class == `OFD_CLS_SR1 |=> !sr_write_q)
		else $error("source class wrote");
	a_pair3_no_sp: assert property (dec_valid && sel_class == `OFD_CLS_RP3
		&& sel_code[2:0] == 3'h0 |=> illegal_q)
		else $error("narrow pair class took stack pointer");
	a_flag_pass: assert property (flag_code >= 3'h2 && flag_code <= 3'h4 |=> flag_sel_q == $past(flag_code))
		else $error("flag select wrong");
	a_imm_width: assert property (1'b1 |=> imm_word_q[7:0] == $past(imm_lo)
		&& imm_word_q[15:8] == $past(imm_hi) && imm_bit_q == $past(imm_lo[2:0]))
		else $error("immediate fields wrong");
	a_reset_clears: assert property (@(posedge core_clk) disable iff (1'b0) !rst_n |=> !res_valid_q && imm_word_q == 16'h0000)
		else $error("outputs not cleared by reset");
	c_illegal: cover property (illegal_q);
	c_write: cover property (sr_write_q);
	c_back_to_back: cover property (res_valid_q ##1 res_valid_q);
endmodule
bind ofd_decoder ofd_decoder_props u_props (.core_clk, .rst_n, .dec_valid, .sel_class, .sel_code,
	.flag_code, .imm_lo, .imm_hi, .res_valid_q, .sr_write_q, .illegal_q, .flag_sel_q, .imm_word_q, .imm_bit_q);
`default_nettype wire

// ---- test/ofd_exec_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ofd_exec_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Decoded results
	input wire logic sr_write_q,
	input wire logic illegal_q,
	// Committed special register writes
	output logic [15:0] write_cnt_q
);
	always @(posedge core_clk) begin
		if (!rst_n) begin
			write_cnt_q <= 16'h0000;
		end else if (sr_write_q && !illegal_q) begin
			write_cnt_q <= write_cnt_q + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// ---- test/ofd_decoder_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ofd_consts.vh"
module ofd_decoder_test;
	logic core_clk, rst_n, dec_valid, res_valid_q, byte_reg_alt_q, sr_wide_q, sr_write_q, illegal_q;
	logic [3:0] sel_class, addr_mode_q, p_c, cls;
	logic [5:0] sel_code, sr_sel_q, p_s;
	logic [2:0] flag_code, byte_reg_q, rp_sel_q, flag_sel_q, imm_bit_q, p_f;
	logic [4:0] irf_code, irf_sel_q, p_i;
	logic [7:0] imm_lo, imm_hi, working_reg_offset_q, imm_byte_q;
	logic [15:0] imm_word_q, write_cnt_q, p_w, exp_w;
	logic p_v, lg;
	integer seed, n, error_cnt, total_checks;
	ofd_decoder u_dut (.core_clk, .rst_n, .dec_valid, .sel_class, .sel_code, .flag_code, .irf_code,
		.imm_lo, .imm_hi, .res_valid_q, .byte_reg_q, .byte_reg_alt_q, .sr_sel_q, .sr_wide_q, .sr_write_q,
		.rp_sel_q, .addr_mode_q, .flag_sel_q, .irf_sel_q, .illegal_q, .working_reg_offset_q, .imm_byte_q,
		.imm_word_q, .imm_bit_q);
	ofd_exec_model u_model (.core_clk, .rst_n, .sr_write_q, .illegal_q, .write_cnt_q);
	always #5 core_clk = ~core_clk;
	function automatic logic legal(input logic [3:0] c, input logic [5:0] s);
		case (c)
			`OFD_CLS_R2, `OFD_CLS_RP3, `OFD_CLS_RPA1: return s >= 1 && s <= 3;
			`OFD_CLS_SR: return s < 6'h0e ? s != 5 : (s >= 6'h10 && s <= 6'h14) || s inside {6'h17, 6'h18, 6'h1a, 6'h1b, 6'h28};
			`OFD_CLS_SR1: return (s < 6'h0e && !(s inside {5, 6'h0a, 6'h0c})) || s == 6'h19 || (s >= 6'h20 && s <= 6'h23);
			`OFD_CLS_SR2: return s < 6'h0e && !(s inside {5, 6'h0a, 6'h0c});
			`OFD_CLS_RP: return s < 4;
			`OFD_CLS_RP1, `OFD_CLS_RP2: return s < 5;
			`OFD_CLS_RPA: return s >= 1 && s <= 7;
			`OFD_CLS_RPA2: return (s >= 1 && s <= 7) || s >= 6'h0b;
			`OFD_CLS_RPA3: return (s >= 2 && s <= 5) || s >= 6'h0b;
			default: return 1'b1;
		endcase
	endfunction
	function automatic logic [5:0] mask(input logic [3:0] c);
		return c < 3 ? 6'h07 : c < 6 ? 6'h3f : c < 8 ? 6'h01 : c < 12 ? 6'h07 : 6'h0f;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input logic v, input logic [3:0] c, input logic [5:0] s);
		logic [15:0] w;
		w = $random(seed);
		@(posedge core_clk);
		dec_valid <= v;
		sel_class <= c;
		sel_code <= s;
		flag_code <= $random(seed);
		irf_code <= $random(seed);
		imm_lo <= w[7:0];
		imm_hi <= w[15:8];
		#1;
		lg = legal(p_c, p_s);
		chk(res_valid_q, p_v);
		chk(illegal_q, p_v && !lg);
		chk(sr_write_q, p_v && lg && p_c inside {`OFD_CLS_SR, `OFD_CLS_SR2, `OFD_CLS_SR3});
		if (p_v && lg && p_c < 3) chk({byte_reg_alt_q, byte_reg_q}, {p_c == `OFD_CLS_R1, p_s[2:0]});
		if (p_v && lg && p_c inside {[3:7]}) chk({sr_wide_q, sr_sel_q}, {p_c > 5, p_s});
		if (p_v && lg && p_c[3:2] == 2'b10) chk(rp_sel_q, (p_c == `OFD_CLS_RP1 && p_s == 0) ? 5 : p_s);
		if (p_v && lg && p_c[3:2] == 2'b11) chk(addr_mode_q, p_s);
		if (p_v && p_c == `OFD_CLS_R1) chk(byte_reg_alt_q, 1'b1);
		if (p_v && p_c == `OFD_CLS_SR2) chk(sr_write_q, lg);
		if (p_v && p_c inside {`OFD_CLS_SR3, `OFD_CLS_SR4}) chk(sr_sel_q, {5'h00, p_s[0]});
		if (p_v && p_c inside {`OFD_CLS_RPA, `OFD_CLS_RPA1}) chk(illegal_q, !lg);
		if (p_v && p_c == `OFD_CLS_RPA3) chk(illegal_q, !lg);
		chk(flag_sel_q, (p_f >= 2 && p_f <= 4) ? p_f : 0);
		chk(irf_sel_q, (p_i <= 12 || (p_i >= 16 && p_i <= 20)) ? p_i : 0);
		chk({imm_word_q, imm_bit_q}, {p_w, p_w[2:0]});
		chk({working_reg_offset_q, imm_byte_q}, {p_w[7:0], p_w[7:0]});
		if (p_v && lg && p_c inside {`OFD_CLS_SR, `OFD_CLS_SR2, `OFD_CLS_SR3}) exp_w++;
		{p_v, p_c, p_s, p_f, p_i, p_w} = {v, c, s, flag_code, irf_code, w};
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{core_clk, rst_n, dec_valid, sel_class, sel_code, flag_code, irf_code, imm_lo, imm_hi} = '0;
		{p_v, p_c, p_s, p_f, p_i, p_w, exp_w} = '0;
		seed = 32'h05b0c336;
		error_cnt = 0;
		total_checks = 0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		for (n = 0; n < 1400; n++) begin
			cls = n < 1024 ? n[9:6] : $random(seed);
			step(($random(seed) & 7) != 0, cls, (n < 1024 ? n[5:0] : $random(seed)) & mask(cls));
		end
		step(1'b0, 4'h0, 6'h00);
		step(1'b0, 4'h0, 6'h00);
		chk(write_cnt_q, exp_w);
		@(posedge core_clk);
		rst_n <= 1'b0;
		dec_valid <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(res_valid_q, 1'b0);
		chk(imm_word_q, `OFD_RESET_ZERO);
		end_of_test;
	end
endmodule
`default_nettype wire
